// >>> verilog/card_host_pkg.sv
package card_host_pkg;

  // Operating modes of the card as seen by the host
  typedef enum logic [1:0] {
    MODE_MEMORY = 2'b00,
    MODE_IO = 2'b01,
    MODE_DISK = 2'b10
  } card_mode_e;

  // Host cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_DONE = 3'b100
  } cyc_state_e;

  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Strobe phase timing, in ns, and derived cycle counts at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 80;
  localparam int HOLD_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;

endpackage : card_host_pkg

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import card_host_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic pin_sync_out
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = pin_in;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  assign pin_sync_out = state_q.sync;

endmodule : pin_sync

// >>> verilog/card_host_ctrl.sv
`timescale 1ns/1ps
// Function
// - During an ultra-DMA read the host captures data on both edges of the card's strobe.
// - In memory mode the host pulses the write strobe to write card and configuration registers.
// - In I/O mode the write strobe only writes configuration registers, never the data port.
// - In disk mode the host holds the unused write strobe at the supply level.
// - The host selects disk mode by driving disk_mode_select_n to ground.
module card_host_ctrl
  import card_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire card_mode_e mode,
  input wire logic wr_req,
  input wire logic wr_cfg,
  output logic wr_ack,
  output logic wr_refused,
  input wire logic udma_wr_active,
  input wire logic udma_wr_valid,
  input wire logic [DATA_W-1:0] udma_wr_data,
  output logic udma_wr_ready,
  input wire logic udma_rd_active,
  output logic udma_rd_valid,
  output logic [DATA_W-1:0] udma_rd_data,
  output logic stall_seen,
  output logic port_is_16bit,
  output logic word_xfer,
  output logic write_protect,
  input wire logic card_wait_n,
  input wire logic io_ready_n,
  input wire logic udma_write_ready_n,
  input wire logic udma_read_strobe,
  input wire logic card_wp,
  input wire logic io_port_width16_n,
  input wire logic ide_word_xfer_n,
  input wire logic [DATA_W-1:0] card_data_in,
  output logic [DATA_W-1:0] card_data_out,
  output logic card_data_oe,
  output logic write_strobe_n,
  output logic disk_mode_select_n
);

  logic wait_n_s;
  logic io_ready_n_n_s;
  logic dmardy_n_s;
  logic udma_read_strobe_s;
  logic wp_s;
  logic io_port_width16_n_n_s;
  logic ide_word_xfer_n_n_s;
  logic [DATA_W-1:0] data_in_s;

  // Data bus synced alongside the strobe so both arrive together
  for (genvar b = 0; b < DATA_W; b++) begin : g_data_sync
    pin_sync #(.RST_VAL(1'b0)) u_sync_data (
      .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(card_data_in[b]), .pin_sync_out(data_in_s[b]));
  end

  pin_sync #(.RST_VAL(1'b1)) u_sync_wait (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(card_wait_n), .pin_sync_out(wait_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_io_ready_n (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(io_ready_n), .pin_sync_out(io_ready_n_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_dmardy (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(udma_write_ready_n),
    .pin_sync_out(dmardy_n_s));
  pin_sync #(.RST_VAL(1'b0)) u_sync_udma_read_strobe (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(udma_read_strobe), .pin_sync_out(udma_read_strobe_s));
  pin_sync #(.RST_VAL(1'b0)) u_sync_wp (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(card_wp), .pin_sync_out(wp_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_io_port_width16_n (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(io_port_width16_n), .pin_sync_out(io_port_width16_n_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_ide_word_xfer_n (
    .sys_clk(sys_clk), .rst_n(rst_n), .pin_in(ide_word_xfer_n), .pin_sync_out(ide_word_xfer_n_n_s));

  typedef struct packed {
    cyc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic we_n;
    logic ack;
    logic refused;
    logic strobe_prev;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] dout;
    logic oe;
    logic stall;
    logic p16;
    logic wx;
    logic wp;
  } host_s;

  host_s s_q;
  host_s s_d;
  logic stall_now;
  logic wr_allowed;

  // Stall source depends on mode; UDMA bursts suspend the IO_READY_N meaning
  always_comb begin
    unique case (mode)
      MODE_MEMORY: stall_now = !wait_n_s;
      MODE_IO: stall_now = !wait_n_s;
      MODE_DISK: stall_now = !udma_wr_active && !udma_rd_active && io_ready_n_n_s;
      default: stall_now = 1'b0;
    endcase
  end

  // Disk mode never strobes; I/O mode only for configuration writes
  always_comb begin
    unique case (mode)
      MODE_MEMORY: wr_allowed = 1'b1;
      MODE_IO: wr_allowed = wr_cfg;
      MODE_DISK: wr_allowed = 1'b0;
      default: wr_allowed = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.refused = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.strobe_prev = udma_read_strobe_s;
    s_d.stall = stall_now;
    s_d.p16 = (mode == MODE_IO) && !io_port_width16_n_n_s;
    s_d.wx = (mode == MODE_DISK) && !ide_word_xfer_n_n_s;
    s_d.wp = (mode == MODE_MEMORY) ? wp_s : 1'b0;
    // Capture on every strobe transition, rising or falling
    if (mode == MODE_DISK && udma_rd_active && (udma_read_strobe_s != s_q.strobe_prev)) begin
      s_d.rd_valid = 1'b1;
      s_d.rd_data = data_in_s;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.we_n = 1'b1;
        if (wr_req && !wr_allowed) begin
          s_d.refused = 1'b1;
        end
        // Refused request must not swallow a word the ready handshake took
        if (wr_req && wr_allowed) begin
          s_d.dout = card_data_out_src(udma_wr_data);
          s_d.oe = 1'b1;
          s_d.cnt = CNT_W'(SETUP_CYC - 1);
          s_d.st = ST_SETUP;
        end else if (mode == MODE_DISK && udma_wr_active && udma_wr_valid && !dmardy_n_s) begin
          s_d.dout = udma_wr_data;
          s_d.oe = 1'b1;
        end else if (!(mode == MODE_DISK && udma_wr_active)) begin
          s_d.oe = 1'b0;
        end
      end
      ST_SETUP: begin
        if (s_q.cnt == '0) begin
          s_d.we_n = 1'b0;
          s_d.cnt = CNT_W'(STROBE_CYC - 1);
          s_d.st = ST_STROBE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      ST_STROBE: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (!stall_now) begin
          s_d.we_n = 1'b1;
          s_d.cnt = CNT_W'(HOLD_CYC - 1);
          s_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (s_q.cnt == '0) begin
          s_d.oe = 1'b0;
          s_d.st = ST_DONE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      ST_DONE: begin
        s_d.ack = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  function automatic logic [DATA_W-1:0] card_data_out_src(input logic [DATA_W-1:0] d);
    card_data_out_src = d;
  endfunction : card_data_out_src

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: ST_IDLE, cnt: '0, we_n: 1'b1, ack: 1'b0, refused: 1'b0,
               strobe_prev: 1'b0, rd_valid: 1'b0, rd_data: DATA_RST, dout: DATA_RST,
               oe: 1'b0, stall: 1'b0, p16: 1'b0, wx: 1'b0, wp: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign wr_ack = s_q.ack;
  assign wr_refused = s_q.refused;
  assign udma_wr_ready = (mode == MODE_DISK) && udma_wr_active && !dmardy_n_s
                         && (s_q.st == ST_IDLE);
  assign udma_rd_valid = s_q.rd_valid;
  assign udma_rd_data = s_q.rd_data;
  assign stall_seen = s_q.stall;
  assign port_is_16bit = s_q.p16;
  assign word_xfer = s_q.wx;
  assign write_protect = s_q.wp;
  assign card_data_out = s_q.dout;
  assign card_data_oe = s_q.oe;
  // Held high in disk mode, unused there
  assign write_strobe_n = (mode == MODE_DISK) ? 1'b1 : s_q.we_n;
  assign disk_mode_select_n = (mode == MODE_DISK) ? 1'b0 : 1'b1;

endmodule : card_host_ctrl

// >>> dv/card_host_ctrl_props.sv
`timescale 1ns/1ps
module card_host_ctrl_props
  import card_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire card_mode_e mode,
  input wire logic wr_ack,
  input wire logic udma_wr_ready,
  input wire logic udma_rd_valid,
  input wire logic port_is_16bit,
  input wire logic word_xfer,
  input wire logic write_protect,
  input wire logic io_port_width16_n,
  input wire logic ide_word_xfer_n,
  input wire logic card_data_oe,
  input wire logic write_strobe_n,
  input wire logic disk_mode_select_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_dsel; disk_mode_select_n == (mode != MODE_DISK); endproperty
  a_dsel: assert property (p_dsel) else $error("mode pin wrong");
  property p_wsd; mode == MODE_DISK |-> write_strobe_n; endproperty
  a_wsd: assert property (p_wsd) else $error("strobe in disk mode");
  property p_ack; wr_ack |-> mode != MODE_DISK; endproperty
  a_ack: assert property (p_ack) else $error("write done in disk mode");
  property p_oe; !write_strobe_n |-> card_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("strobe without data");
  property p_wlen; $fell(write_strobe_n) |-> !write_strobe_n [*8]; endproperty
  a_wlen: assert property (p_wlen) else $error("strobe too short");
  property p_w16; (mode == MODE_IO && !io_port_width16_n) [*5] |-> port_is_16bit; endproperty
  a_w16: assert property (p_w16) else $error("width flag missed");
  property p_word; (mode == MODE_DISK && !ide_word_xfer_n) [*5] |-> word_xfer; endproperty
  a_word: assert property (p_word) else $error("word flag missed");
  property p_wp; mode != MODE_MEMORY |-> !write_protect; endproperty
  a_wp: assert property (p_wp) else $error("protect outside memory");
  property p_rdv; udma_rd_valid |-> mode == MODE_DISK; endproperty
  a_rdv: assert property (p_rdv) else $error("read word outside disk");
  property p_wrdy; udma_wr_ready |-> mode == MODE_DISK; endproperty
  a_wrdy: assert property (p_wrdy) else $error("ready outside disk");
  c_ack: cover property (wr_ack);
  c_rdv: cover property (udma_rd_valid);
  c_wrdy: cover property (udma_wr_ready);
endmodule : card_host_ctrl_props
bind card_host_ctrl card_host_ctrl_props u_props (.sys_clk, .rst_n, .mode, .wr_ack,
  .udma_wr_ready, .udma_rd_valid, .port_is_16bit, .word_xfer, .write_protect,
  .io_port_width16_n, .ide_word_xfer_n, .card_data_oe, .write_strobe_n, .disk_mode_select_n);

// >>> dv/card_model.sv
`timescale 1ns/1ps
module card_model
  import card_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic rdy,
  input wire logic w16,
  input wire logic tog,
  input wire logic [DATA_W-1:0] rd_word,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] card_data_out,
  output logic card_wait_n,
  output logic io_ready_n,
  output logic udma_write_ready_n,
  output logic udma_read_strobe,
  output logic card_wp,
  output logic io_port_width16_n,
  output logic ide_word_xfer_n,
  output logic [DATA_W-1:0] card_data_in,
  output logic [DATA_W-1:0] wr_word
);
  logic we_q;
  assign card_wait_n = !stall;
  assign io_ready_n = stall;
  assign udma_write_ready_n = !rdy;
  assign card_wp = 1'b0;
  assign io_port_width16_n = !w16;
  assign ide_word_xfer_n = !w16;
  always @(posedge sys_clk) begin
    we_q <= write_strobe_n;
    if (!rst_n) begin
      udma_read_strobe <= 1'b0;
      card_data_in <= '0;
      wr_word <= '0;
    end else begin
      if (tog) begin
        udma_read_strobe <= !udma_read_strobe;
        card_data_in <= rd_word;
      end
      if (write_strobe_n && !we_q) wr_word <= card_data_out;
    end
  end
endmodule : card_model

// >>> dv/card_host_ctrl_tb_top.sv
`timescale 1ns/1ps
module card_host_ctrl_tb_top import card_host_pkg::*;;
  card_mode_e mode;
  logic sys_clk, rst_n, wr_req, wr_cfg, wr_ack, wr_refused, udma_wr_active, udma_wr_valid;
  logic udma_wr_ready, udma_rd_active, udma_rd_valid, stall_seen, port_is_16bit, word_xfer;
  logic write_protect, card_wait_n, io_ready_n, udma_write_ready_n, udma_read_strobe, card_wp;
  logic io_port_width16_n, ide_word_xfer_n, card_data_oe, write_strobe_n, disk_mode_select_n;
  logic stall, rdy, w16, tog;
  logic [DATA_W-1:0] udma_wr_data, udma_rd_data, card_data_in, card_data_out, rd_word, wr_word;
  logic [31:0] seed = 32'h2cdd_3012;
  logic [31:0] r;
  int miscompares, num_checks, n;
  card_host_ctrl uut (.sys_clk, .rst_n, .mode, .wr_req, .wr_cfg, .wr_ack, .wr_refused,
    .udma_wr_active, .udma_wr_valid, .udma_wr_data, .udma_wr_ready, .udma_rd_active,
    .udma_rd_valid, .udma_rd_data, .stall_seen, .port_is_16bit, .word_xfer, .write_protect,
    .card_wait_n, .io_ready_n, .udma_write_ready_n, .udma_read_strobe, .card_wp,
    .io_port_width16_n, .ide_word_xfer_n, .card_data_in, .card_data_out, .card_data_oe,
    .write_strobe_n, .disk_mode_select_n);
  card_model card (.sys_clk, .rst_n, .stall, .rdy, .w16, .tog, .rd_word, .write_strobe_n,
    .card_data_out, .card_wait_n, .io_ready_n, .udma_write_ready_n, .udma_read_strobe,
    .card_wp, .io_port_width16_n, .ide_word_xfer_n, .card_data_in, .wr_word);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic refused(card_mode_e m, logic c);
    return m == MODE_DISK || (m == MODE_IO && !c);
  endfunction : refused
  task chk(string s, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wait_neg(input int w);
    logic f;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n == 40) stall = 1'b0;
      f = (w == 0) ? wr_ack : ((w == 1) ? udma_rd_valid : udma_wr_ready);
    end while (f !== 1'b1 && wr_refused !== 1'b1 && n < 300);
    if (f !== 1'b1 && wr_refused !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED wait exp 1 got 0");
    end
  endtask : wait_neg
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    {rst_n, wr_req, wr_cfg, udma_wr_active, udma_wr_valid, udma_rd_active} = '0;
    {stall, rdy, w16, tog, udma_wr_data, rd_word} = '0;
    mode = MODE_MEMORY;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      @(posedge sys_clk);
      mode <= card_mode_e'(i % 3);
      stall <= 1'b1;
      w16 <= (i < 3) ? 1'b1 : (r[0] && i != 4);
      repeat (6) @(negedge sys_clk);
      chk("stall", 1, stall_seen);
      chk("w16", i % 3 == 1 && w16, port_is_16bit);
      chk("word", i % 3 == 2 && w16, word_xfer);
      chk("wp", 0, write_protect);
      chk("sel", i % 3 != 2, disk_mode_select_n);
      stall <= 1'b0;
      $display("status test %0d done", i);
    end
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      @(posedge sys_clk);
      mode <= card_mode_e'(i % 3);
      wr_cfg <= i > 2;
      stall <= i == 3 || i == 4;
      udma_wr_data <= r[15:0];
      @(posedge sys_clk);
      wr_req <= 1'b1;
      @(posedge sys_clk);
      wr_req <= 1'b0;
      wait_neg(0);
      chk("refused", refused(mode, wr_cfg), wr_refused);
      if (!refused(mode, wr_cfg)) chk("ack", 1, wr_ack);
      if (!refused(mode, wr_cfg)) chk("wword", r[15:0], wr_word);
      if (!refused(mode, wr_cfg)) chk("slow", i == 3 || i == 4, n > 40);
      $display("write test %0d done", i);
    end
    @(posedge sys_clk);
    mode <= MODE_DISK;
    udma_rd_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      @(posedge sys_clk);
      rd_word <= r[15:0];
      tog <= 1'b1;
      @(posedge sys_clk);
      tog <= 1'b0;
      wait_neg(1);
      chk("rvalid", 1, udma_rd_valid);
      chk("rdata", r[15:0], udma_rd_data);
    end
    $display("read test done");
    r = rnd();
    @(posedge sys_clk);
    udma_rd_active <= 1'b0;
    udma_wr_active <= 1'b1;
    udma_wr_valid <= 1'b1;
    udma_wr_data <= r[15:0];
    repeat (6) @(negedge sys_clk);
    chk("wrdy", 0, udma_wr_ready);
    @(posedge sys_clk);
    rdy <= 1'b1;
    wait_neg(2);
    @(posedge sys_clk);
    udma_wr_valid <= 1'b0;
    @(negedge sys_clk);
    chk("udata", r[15:0], card_data_out);
    chk("udma oe", 1, card_data_oe);
    $display("udma write test done");
    give_verdict();
  end
endmodule : card_host_ctrl_tb_top
